// File: testbench/sdr_core_monitor.sv
`timescale 1ns/1ns
module sdr_core_monitor
  import sdr_pkg::*;
(
  input wire logic      i_clk,
  input wire logic      i_resetn,
  input wire logic      i_ce,
  input wire logic      i_cke,
  input wire sdr_pins_t i_pins,
  input wire logic      o_dq_oe_n,
  input wire logic      o_self_refresh
);
  logic       fp2_r;
  logic       run;
  logic [2:0] op;
  // decode; a deselected bus counts as idle
  assign run = i_ce && i_cke;
  assign op  = i_pins.cs_n ? 3'h7 : {i_pins.ras_n, i_pins.cas_n, i_pins.we_n};
  // full page at latency 2, tracked from mode writes
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) fp2_r <= 1'b0;
    else if (run && !o_self_refresh && op == 3'h0) fp2_r <= i_pins.addr[2:0] == 3'h7 && i_pins.addr[6:4] != 3'h3;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_dqm_float;
    run && $past(i_cke) && i_pins.dqm && !o_self_refresh ##1 run |=> o_dq_oe_n;
  endproperty
  property p_sr_stay;
    o_self_refresh && !i_cke |=> o_self_refresh;
  endproperty
  property p_sr_exit;
    o_self_refresh && run && !$past(i_cke) ##1 run |-> o_self_refresh ##1 !o_self_refresh;
  endproperty
  // needs the word before the stop fetched, hence the idle check
  property p_fp_stop;
    fp2_r && run && $past(run) && $past(op) == 3'h7 && op == 3'h6 && !o_dq_oe_n && !$past(o_dq_oe_n)
      ##1 run |-> !o_dq_oe_n ##1 o_dq_oe_n;
  endproperty
  a_dqm_float: assert property (p_dqm_float)
    else $error("read word not blanked after mask");
  a_sr_stay: assert property (p_sr_stay)
    else $error("self refresh left while clock enable low");
  a_sr_exit: assert property (p_sr_exit)
    else $error("self refresh exit not on second edge");
  a_fp_stop: assert property (p_fp_stop)
    else $error("full page tail length wrong");
  c_dqm: cover property (run && i_pins.dqm ##2 o_dq_oe_n);
  c_exit: cover property (o_self_refresh ##1 !o_self_refresh);
  c_stop: cover property (fp2_r && op == 3'h6 && !o_dq_oe_n);
endmodule : sdr_core_monitor

bind sdr_core sdr_core_monitor i_sdr_core_monitor (
  .i_clk          (i_clk),
  .i_resetn       (i_resetn),
  .i_ce           (i_ce),
  .i_cke          (i_cke),
  .i_pins         (i_pins),
  .o_dq_oe_n      (o_dq_oe_n),
  .o_self_refresh (o_self_refresh)
);

// File: testbench/sdr_ctl_model.sv
`timescale 1ns/1ns
module sdr_ctl_model
  import sdr_pkg::*;
(
  input  wire logic            i_clk,
  output logic                 o_cke,
  output sdr_pins_t            o_pins,
  output logic      [DQ_W-1:0] o_dq
);
  localparam int TCK_NS = 20;
  localparam int TRP_NS = 20;
  localparam int TRC_NS = 60;
  localparam int TWR_CK = 2;

  // whole clocks, a fraction rounds up
  function automatic int clk_of(input int ns);
    return (ns + TCK_NS - 1) / TCK_NS;
  endfunction : clk_of

  initial begin
    o_cke  = 1'b1;
    o_pins = sdr_pins_t'(19'h78000);
    o_dq   = 8'h00;
  end

  // change just after an edge, hold to the next
  task automatic issue(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic m,
                       input logic [DQ_W-1:0] d, input logic k);
    @(posedge i_clk);
    o_pins <= '{cs_n: 1'b0, ras_n: op[2], cas_n: op[1], we_n: op[0], ba: 2'h0, addr: a, dqm: m};
    o_dq   <= d;
    o_cke  <= k;
  endtask : issue

  // idle; data line toggles since nobody owns it
  task automatic nop(input int n);
    repeat (n) issue(3'h7, 12'h000, 1'b0, ~o_dq, 1'b1);
  endtask : nop

  // settle, close all banks, two refreshes, then mode
  task automatic init(input logic [ADDR_W-1:0] mode);
    nop(clk_of(200000));
    issue(3'h2, 12'h400, 1'b0, o_dq, 1'b1);
    nop(clk_of(TRP_NS));
    repeat (2) begin
      issue(3'h1, 12'h000, 1'b0, o_dq, 1'b1);
      nop(clk_of(TRC_NS));
    end
    issue(3'h0, mode, 1'b0, o_dq, 1'b1);
    nop(1);
  endtask : init

  task automatic wr_recover;
    nop(TWR_CK);
  endtask : wr_recover

  task automatic exit_wait;
    nop(clk_of(TRC_NS));
  endtask : exit_wait

  // auto precharged bank stays shut for the precharge time
  task automatic ap_wait;
    nop(clk_of(TRP_NS));
  endtask : ap_wait
endmodule : sdr_ctl_model

// File: testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import sdr_pkg::*;
  localparam logic [2:0] OP_ACT = 3'h3;
  localparam logic [2:0] OP_RD  = 3'h5;
  localparam logic [2:0] OP_WR  = 3'h4;
  localparam logic [2:0] OP_BST = 3'h6;
  localparam logic [2:0] OP_PRE = 3'h2;
  localparam logic [2:0] OP_REF = 3'h1;
  localparam logic [2:0] OP_MRS = 3'h0;
  localparam logic [2:0] OP_NOP = 3'h7;
  // longest gap between refreshes in clocks, 64 ms over 4096 rows at 20 ns
  localparam int         REF_GAP_CK = 64000000 / 4096 / 20;
  time               t0;
  logic              clk;
  logic              resetn;
  logic              ce;
  logic              cke;
  sdr_pins_t         pins;
  logic [DQ_W-1:0]   dq_w;
  logic [DQ_W-1:0]   dq_r;
  logic              dq_oe_n;
  logic              self_ref;
  logic [BANK_N-1:0] bank_open;
  int                n_mismatch;
  int                n_checks;

  sdr_core i_sdr_core (
    .i_clk          (clk),
    .i_resetn       (resetn),
    .i_ce           (ce),
    .i_cke          (cke),
    .i_pins         (pins),
    .i_dq           (dq_w),
    .o_dq           (dq_r),
    .o_dq_oe_n      (dq_oe_n),
    .o_self_refresh (self_ref),
    .o_bank_open    (bank_open)
  );
  sdr_ctl_model i_sdr_ctl_model (
    .i_clk  (clk),
    .o_cke  (cke),
    .o_pins (pins),
    .o_dq   (dq_w)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic end_sim;
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  // taken at the edge after return; outputs read here are the samples of the edge before it
  task automatic cmd(input logic [2:0] op, input logic [11:0] a, input logic m, input logic [7:0] d, input logic k);
    i_sdr_ctl_model.issue(op, a, m, d, k);
  endtask : cmd

  task automatic idle(input int n);
    i_sdr_ctl_model.nop(n);
  endtask : idle

  // two gapless bursts, one masked beat, read back with one blanked word
  task automatic s_mask;
    logic [7:0] wd [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'hee, 8'h77, 8'h88};
    logic [7:0] rx [4] = '{8'h55, 8'h22, 8'h77, 8'h88};
    cmd(OP_ACT, 12'h005, 1'b0, 8'h00, 1'b1);
    idle(1);
    for (int i = 0; i < 8; i++) cmd(i % 4 == 0 ? OP_WR : OP_NOP, 12'h000, i == 5, wd[i], 1'b1);
    i_sdr_ctl_model.wr_recover();
    for (int i = 0; i < 7; i++) begin
      cmd(i == 0 ? OP_RD : OP_NOP, 12'h000, i == 2, 8'h00, 1'b1);
      if (i > 2) check({7'h0, dq_oe_n}, {7'h0, i == 5});
      if (i > 2 && i != 5) check(dq_r, rx[i - 3]);
    end
  endtask : s_mask

  // full page read stopped after three fetches; tail follows latency
  task automatic s_stop(input logic [2:0] cl);
    cmd(OP_PRE, 12'h400, 1'b0, 8'h00, 1'b1);
    idle(1);
    cmd(OP_MRS, {5'h00, cl, 4'h7}, 1'b0, 8'h00, 1'b1);
    idle(1);
    cmd(OP_ACT, 12'h005, 1'b0, 8'h00, 1'b1);
    idle(1);
    for (int i = 0; i <= 4 + cl; i++) begin
      cmd(i == 0 ? OP_RD : (i == 3 ? OP_BST : OP_NOP), 12'h000, 1'b0, 8'h00, 1'b1);
      if (i > 4) check({7'h0, dq_oe_n}, {7'h0, i == 4 + cl});
      if (i == 3 + cl) check(dq_r, 8'h77);
    end
  endtask : s_stop

  // enter with banks closed, exit, then a row opens again
  task automatic s_self;
    cmd(OP_PRE, 12'h400, 1'b0, 8'h00, 1'b1);
    idle(2);
    check({4'h0, bank_open}, 8'h00);
    for (int i = 0; i < 5; i++) cmd(i == 0 ? OP_REF : OP_NOP, 12'h000, 1'b0, 8'h00, 1'b0);
    check({7'h0, self_ref}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      cmd(OP_NOP, 12'h000, 1'b0, 8'h00, 1'b1);
      if (i > 0) check({7'h0, self_ref}, {7'h0, i < 3});
    end
    i_sdr_ctl_model.exit_wait();
    cmd(OP_ACT, 12'h005, 1'b0, 8'h00, 1'b1);
    idle(2);
    check({4'h0, bank_open}, 8'h01);
  endtask : s_self

  // interleaved burst of four with auto precharge; bank shuts on the last beat
  task automatic s_auto;
    logic [7:0] rx [4] = '{8'h22, 8'h55, 8'h88, 8'h77};
    cmd(OP_PRE, 12'h400, 1'b0, 8'h00, 1'b1);
    idle(1);
    cmd(OP_MRS, 12'h02a, 1'b0, 8'h00, 1'b1);
    idle(1);
    cmd(OP_ACT, 12'h005, 1'b0, 8'h00, 1'b1);
    idle(1);
    for (int i = 0; i < 7; i++) begin
      cmd(i == 0 ? OP_RD : OP_NOP, 12'h401, 1'b0, 8'h00, 1'b1);
      if (i > 2) check(dq_r, rx[i - 3]);
      if (i == 4 || i == 5) check({4'h0, bank_open}, {7'h0, i == 4});
    end
    i_sdr_ctl_model.ap_wait();
    cmd(OP_ACT, 12'h005, 1'b0, 8'h00, 1'b1);
    idle(2);
    check({4'h0, bank_open}, 8'h01);
  endtask : s_auto

  initial begin
    n_mismatch = 0;
    n_checks   = 0;
    ce         = 1'b1;
    resetn     = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    i_sdr_ctl_model.init(12'h022);
    t0 = $time;
    s_mask;
    s_stop(3'h2);
    s_stop(3'h3);
    s_self;
    s_auto;
    // no refresh follows init, so the scenarios must fit in one refresh gap
    check({7'h0, ($time - t0) / 20 >= REF_GAP_CK}, 8'h00);
    end_sim;
  end

  // hang guard
  initial begin
    #400000;
    n_mismatch++;
    end_sim;
  end
endmodule : tb_top

// File: verilog/sdr_core.sv
// Overview of operation
// - read DQM floats outputs two clocks later
// - write DQM masks same-edge data, no latency
// - self refresh exit on second edge after CKE
// - terminated full page read drains CAS latency
`timescale 1ns/1ns
module sdr_core
  import sdr_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_resetn,
  input  wire logic            i_ce,
  input  wire logic            i_cke,
  input  wire sdr_pins_t       i_pins,
  input  wire logic [DQ_W-1:0] i_dq,
  output logic      [DQ_W-1:0] o_dq,
  output logic                 o_dq_oe_n,
  output logic                 o_self_refresh,
  output logic [BANK_N-1:0]    o_bank_open
);

  typedef struct packed {
    sdr_pwr_t                      pwr;
    logic [1:0]                    exit_cnt;
    logic                          cke_r;
    logic [2:0]                    mode_bl;
    logic                          mode_il;
    logic [2:0]                    mode_cl;
    logic [BANK_N-1:0]             open;
    logic [BANK_N-1:0][ROW_W-1:0]  row;
    logic                          b_act;
    logic                          b_wr;
    logic                          b_ap;
    logic [BANK_W-1:0]             b_bank;
    logic [COL_W-1:0]              b_col;
    logic [COL_W-1:0]              b_n;
    logic                          rv1;
    logic                          st_v;
    logic [DQ_W-1:0]               st_d;
    logic                          dqm_r;
    logic                          out_v;
    logic [DQ_W-1:0]               out_d;
  } sdr_state_t;

  sdr_state_t           st_r;
  sdr_state_t           st_nxt;
  sdr_cmd_t             cmd;
  logic                 mem_we;
  logic                 mem_re;
  logic [MEM_AW-1:0]    mem_addr;
  logic [DQ_W-1:0]      mem_rdata;

  // command pins to a command; deselect counts as no operation
  function automatic sdr_cmd_t cmd_decode(input sdr_pins_t p);
    logic [2:0] rcw;
    rcw = {p.ras_n, p.cas_n, p.we_n};
    if (p.cs_n) begin
      return CMD_NOP;
    end
    case (rcw)
      3'h3:    return CMD_ACT;
      3'h5:    return CMD_RD;
      3'h4:    return CMD_WR;
      3'h6:    return CMD_BST;
      3'h2:    return CMD_PRE;
      3'h1:    return CMD_REF;
      3'h0:    return CMD_MRS;
      default: return CMD_NOP;
    endcase
  endfunction : cmd_decode

  // low column bits that wrap inside one burst; full page wraps the whole row
  function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] bl);
    if (bl == MR_BL_FULL) begin
      return '1;
    end
    return COL_W'((10'h1 << bl[1:0]) - 10'h1);
  endfunction : burst_mask

  assign cmd = cmd_decode(i_pins);

  // one process decodes commands, runs the burst and the read pipe
  always_comb begin
    logic               run;
    logic               newcol;
    logic               stop;
    logic               beat;
    logic               full;
    logic [COL_W-1:0]   mask;
    logic [COL_W-1:0]   idx;
    logic [COL_W-1:0]   start;
    logic [COL_W-1:0]   lowc;
    logic [COL_W-1:0]   col;
    logic [BANK_W-1:0]  bank;
    logic               src_v;
    logic [DQ_W-1:0]    src_d;
    run      = 1'b0;
    newcol   = 1'b0;
    stop     = 1'b0;
    beat     = 1'b0;
    full     = 1'b0;
    mask     = '0;
    idx      = '0;
    start    = '0;
    lowc     = '0;
    col      = '0;
    bank     = '0;
    src_v    = 1'b0;
    src_d    = '0;
    st_nxt   = st_r;
    mem_we   = 1'b0;
    mem_re   = 1'b0;
    mem_addr = '0;
    st_nxt.cke_r = i_cke;

    // power state: cke low at a refresh enters self refresh
    case (st_r.pwr)
      PW_RUN: begin
        run = st_r.cke_r;
        if (run && cmd == CMD_REF && !i_cke) begin
          st_nxt.pwr = PW_SELF;
          run        = 1'b0;
        end
      end
      PW_SELF: begin
        if (i_cke) begin
          st_nxt.pwr      = PW_EXIT;
          st_nxt.exit_cnt = 2'h1;
        end
      end
      PW_EXIT: begin
        // a cke drop before the second edge falls back into self refresh
        if (!i_cke) begin
          st_nxt.pwr = PW_SELF;
        end else if (st_r.exit_cnt == SELF_EXIT_EDGE - 2'h1) begin
          st_nxt.pwr      = PW_RUN;
          st_nxt.exit_cnt = 2'h0;
        end
      end
      default: begin
        st_nxt.pwr = PW_RUN;
      end
    endcase

    if (run) begin
      newcol = (cmd == CMD_RD) || (cmd == CMD_WR);
      // any column or stop command, or a precharge of all banks or of the burst's bank, cuts the running burst short
      stop   = newcol || cmd == CMD_BST ||
               (cmd == CMD_PRE && (i_pins.addr[AP_BIT] || i_pins.ba == st_r.b_bank));

      case (cmd)
        CMD_ACT: begin
          st_nxt.open[i_pins.ba] = 1'b1;
          st_nxt.row[i_pins.ba]  = i_pins.addr[ROW_W-1:0];
        end
        CMD_PRE: begin
          if (i_pins.addr[AP_BIT]) begin
            st_nxt.open = '0;
          end else begin
            st_nxt.open[i_pins.ba] = 1'b0;
          end
        end
        CMD_MRS: begin
          st_nxt.mode_bl = i_pins.addr[MR_BL_LSB +: 3];
          st_nxt.mode_il = i_pins.addr[MR_BT_BIT];
          st_nxt.mode_cl = i_pins.addr[MR_CL_LSB +: 3];
        end
        default: begin
        end
      endcase

      // beat of this edge: first beat of a new command or next of the running burst
      full  = (st_r.mode_bl == MR_BL_FULL);
      mask  = burst_mask(st_r.mode_bl);
      beat  = newcol || (st_r.b_act && !stop);
      idx   = newcol ? '0 : st_r.b_n;
      start = newcol ? i_pins.addr[COL_W-1:0] : st_r.b_col;
      bank  = newcol ? i_pins.ba : st_r.b_bank;
      lowc  = (st_r.mode_il && !full) ? (start ^ idx) : COL_W'(start + idx);
      col   = (start & ~mask) | (lowc & mask);
      if (newcol) begin
        st_nxt.b_wr   = (cmd == CMD_WR);
        st_nxt.b_ap   = i_pins.addr[AP_BIT];
        st_nxt.b_bank = i_pins.ba;
        st_nxt.b_col  = i_pins.addr[COL_W-1:0];
      end
      if (stop && !newcol) begin
        st_nxt.b_act = 1'b0;
      end
      if (beat) begin
        st_nxt.b_n   = COL_W'(idx + 1'b1);
        st_nxt.b_act = full || (idx != mask);
        mem_addr     = {bank, st_r.row[bank], col};
        // masked write byte keeps its old array contents
        mem_we = st_nxt.b_wr && !i_pins.dqm;
        mem_re = !st_nxt.b_wr;
        if (!full && idx == mask && st_nxt.b_ap) begin
          st_nxt.open[bank] = 1'b0;
        end
      end

      // read pipe: cas latency 3 adds one stage ahead of the output register
      st_nxt.rv1   = mem_re;
      st_nxt.st_v  = st_r.rv1;
      st_nxt.st_d  = mem_rdata;
      src_v        = (st_r.mode_cl == MR_CL_3) ? st_r.st_v : st_r.rv1;
      src_d        = (st_r.mode_cl == MR_CL_3) ? st_r.st_d : mem_rdata;
      st_nxt.dqm_r = i_pins.dqm;
      st_nxt.out_d = src_d;
      // dqm seen one edge earlier blanks the word driven now
      st_nxt.out_v = src_v && !st_r.dqm_r;
    end else if (st_r.pwr != PW_RUN) begin
      // a self refresh period ends any output that was still pending
      st_nxt.out_v = 1'b0;
      st_nxt.rv1   = 1'b0;
      st_nxt.st_v  = 1'b0;
    end
  end

  // all state of the core moves together; i_ce freezes it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r         <= '0;
      st_r.pwr     <= PW_RUN;
      st_r.cke_r   <= 1'b1;
      st_r.mode_bl <= MR_BL_RST;
      st_r.mode_cl <= MR_CL_RST;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  sdr_mem #(
    .AW (MEM_AW),
    .DW (DQ_W)
  ) u_mem (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_we     (mem_we),
    .i_re     (mem_re),
    .i_addr   (mem_addr),
    .i_wdata  (i_dq),
    .o_rdata  (mem_rdata)
  );

  assign o_dq           = st_r.out_d;
  assign o_dq_oe_n      = !st_r.out_v;
  assign o_self_refresh = (st_r.pwr != PW_RUN);
  assign o_bank_open    = st_r.open;

endmodule : sdr_core

// File: verilog/sdr_mem.sv
`timescale 1ns/1ns
module sdr_mem #(
  parameter int AW = 23,
  parameter int DW = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  input  wire logic          i_ce,
  input  wire logic          i_we,
  input  wire logic          i_re,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);

  typedef struct packed {
    logic [DW-1:0] rdata;
  } sdr_mem_state_t;

  logic [DW-1:0]  mem_r [2**AW];
  sdr_mem_state_t st_r;
  sdr_mem_state_t st_nxt;

  // read data only moves on a read, so suspend holds it
  always_comb begin
    st_nxt = st_r;
    if (i_re) begin
      st_nxt.rdata = mem_r[i_addr];
    end
  end

  // read register resets; the array does not
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // array kept out of the reset process so it maps onto plain ram
  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem_r[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = st_r.rdata;

endmodule : sdr_mem

// File: verilog/sdr_pkg.sv
package sdr_pkg;

  // array geometry
  localparam int BANK_N = 4;
  localparam int BANK_W = 2;
  localparam int ROW_W  = 12;
  localparam int COL_W  = 9;
  localparam int DQ_W   = 8;
  localparam int ADDR_W = 12;
  localparam int MEM_AW = BANK_W + ROW_W + COL_W;

  // address pin that carries auto precharge / all-bank select
  localparam int AP_BIT = 10;

  // mode register field positions
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;

  // mode register codes and reset values
  localparam logic [2:0] MR_BL_FULL = 3'h7;
  localparam logic [2:0] MR_CL_2    = 3'h2;
  localparam logic [2:0] MR_CL_3    = 3'h3;
  localparam logic [2:0] MR_BL_RST  = 3'h0;
  localparam logic [2:0] MR_CL_RST  = 3'h2;

  // timing counts in clocks
  localparam int DQM_READ_LAT  = 2;
  localparam int DQM_WRITE_LAT = 0;
  localparam logic [1:0] SELF_EXIT_EDGE = 2'h2;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_RD,
    CMD_WR,
    CMD_BST,
    CMD_PRE,
    CMD_REF,
    CMD_MRS
  } sdr_cmd_t;

  typedef enum logic [1:0] {
    PW_RUN,
    PW_SELF,
    PW_EXIT
  } sdr_pwr_t;

  // command pins as sampled on a rising edge
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic              dqm;
  } sdr_pins_t;

endpackage : sdr_pkg
